// *** dbf_filter.sv ***
// counter input debounce filter with an apb register port
// assumes pclk at 10 MHz and cnt_in already synchronous to pclk
//
// Notes on behaviour
// - after-stable output follows once level held debounce time
// - after-stable rejects excursions shorter than debounce time
// - before-stable passes accepted edge at once, then waits
// - before-stable edge needs prior level held debounce time
// - before-stable output holds while input keeps toggling
// - before-stable counts first glitch of a burst once
// - bypass passes every glitch to the counter
// - sixteen debounce times, 500 ns to 25.5 ms
// - optional inverter ahead of the debounce stage
// - bypass keeps inversion, ignores debounce time
//
// The APB slave port and the register offsets are this design's own decisions.
module dbf_filter
#(
   // debounce counts per selection; shorten for simulation
   parameter dbf_pkg::dbf_cyc_arr_t DEB_CYCLES = dbf_pkg::DBF_DEB_CYC
)
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire dbf_pkg::dbf_apb_req_t apb_req, // apb request
   output dbf_pkg::dbf_apb_rsp_t apb_rsp, // apb answer
   input wire logic cnt_in, // raw input from the receiver
   output logic cnt_out // filtered level to the counter
);
   import dbf_pkg::*;

   // control register fields
   logic [1:0] mode_f; // mode code
   logic inv; // invert input
   logic [3:0] tsel; // debounce time select
   logic [15:0] edges; // accepted output transitions
   logic [31:0] rdata; // registered read data

   // decode and selection
   wire logic sig; // input after the inverter
   wire logic [DBF_CW-1:0] lim; // selected debounce count
   wire logic lvl; // last sampled level
   wire logic edge_now; // input changed this cycle
   wire logic stable; // level held for the debounce time
   wire dbf_mode_t mode; // decoded mode
   wire logic setup; // apb setup phase
   wire logic wr; // write takes effect
   wire logic hit_ctrl; // control address
   wire logic hit_stat; // status address
   wire logic hit_edge; // edge count address
   wire logic mapped; // any known address
   wire logic [31:0] ctrl_val; // control read view
   wire logic [31:0] next_rdata; // read mux
   logic next_out; // next filter output

   assign sig = cnt_in ^ inv;
   assign lim = DEB_CYCLES[tsel];
   assign mode = (mode_f == 2'h3) ? DBF_BYPASS : dbf_mode_t'(mode_f);
   assign setup = apb_req.psel && !apb_req.penable;
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign hit_ctrl = apb_req.paddr == DBF_OFS_CTRL;
   assign hit_stat = apb_req.paddr == DBF_OFS_STAT;
   assign hit_edge = apb_req.paddr == DBF_OFS_EDGE;
   assign mapped = hit_ctrl || hit_stat || hit_edge;
   assign ctrl_val = (32'(mode_f) << DBF_CTRL_MODE)
      | (32'(inv) << DBF_CTRL_INV)
      | (32'(tsel) << DBF_CTRL_TSEL);
   assign next_rdata = hit_ctrl ? ctrl_val
      : hit_stat ? {29'h0, stable, sig, cnt_out}
      : hit_edge ? {16'h0, edges}
      : 32'h0;

   // answer in the access phase at once; unmapped gives an error
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
   assign apb_rsp.prdata = rdata;

   // stability timer on the inverted input
   dbf_stable_timer u_timer
   (
      .pclk(pclk),
      .presetn(presetn),
      .din(sig),
      .limit(lim),
      .lvl(lvl),
      .edge_now(edge_now),
      .stable(stable)
   );

   // filter decision per mode
   always_comb
   begin
      next_out = cnt_out;
      unique case (mode)
         DBF_AFTER:
         begin
            // follow only a level that has held the full time
            if (stable)
            begin
               next_out = lvl;
            end
         end
         DBF_BEFORE:
         begin
            // an edge after a quiet spell passes at once
            if (edge_now && stable)
            begin
               next_out = sig;
            end
            // otherwise hold through the burst
         end
         DBF_BYPASS:
         begin
            next_out = sig;
         end
      endcase
   end

   // filter output and edge count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_out <= 1'b0;
         edges <= 16'h0;
      end
      else
      begin
         cnt_out <= next_out;
         edges <= edges + 16'(next_out != cnt_out);
      end
   end

   // control register writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_f <= DBF_RST_MODE;
         inv <= DBF_RST_INV;
         tsel <= DBF_RST_TSEL;
      end
      else if (wr && hit_ctrl)
      begin
         mode_f <= apb_req.pwdata[DBF_CTRL_MODE +: 2];
         inv <= apb_req.pwdata[DBF_CTRL_INV];
         tsel <= apb_req.pwdata[DBF_CTRL_TSEL +: 4];
      end
   end

   // read data captured in the setup phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata <= 32'h0;
      end
      else if (setup)
      begin
         rdata <= next_rdata;
      end
   end

   // after-stable: a held level reaches the output next cycle
   property p_after_take;
      @(posedge pclk) disable iff (!presetn)
      mode == DBF_AFTER && stable |=> cnt_out == $past(lvl);
   endproperty
   a_after_take: assert property (p_after_take)
      else $error("after-stable output missed a settled level");

   // after-stable: no change without a full quiet spell
   property p_after_hold;
      @(posedge pclk) disable iff (!presetn)
      mode == DBF_AFTER && !stable |=> $stable(cnt_out);
   endproperty
   a_after_hold: assert property (p_after_hold)
      else $error("after-stable output moved on an unsettled input");

   // before-stable: accepted edge appears on the next cycle
   property p_before_pass;
      @(posedge pclk) disable iff (!presetn)
      mode == DBF_BEFORE && edge_now && stable
         |=> cnt_out == $past(sig);
   endproperty
   a_before_pass: assert property (p_before_pass)
      else $error("before-stable output missed an accepted edge");

   // before-stable: edge without a quiet spell is refused
   property p_before_refuse;
      @(posedge pclk) disable iff (!presetn)
      mode == DBF_BEFORE && edge_now && !stable |=> $stable(cnt_out);
   endproperty
   a_before_refuse: assert property (p_before_refuse)
      else $error("before-stable took an edge with no quiet spell");

   // before-stable: output holds unless an edge is accepted
   property p_before_hold;
      @(posedge pclk) disable iff (!presetn)
      mode == DBF_BEFORE && !(edge_now && stable) |=> $stable(cnt_out);
   endproperty
   a_before_hold: assert property (p_before_hold)
      else $error("before-stable output moved during a burst");

   // before-stable: a second glitch right after is not counted
   property p_before_once;
      @(posedge pclk) disable iff (!presetn)
      mode == DBF_BEFORE && edge_now && stable && lim > DBF_CW'(1)
         |=> !stable;
   endproperty
   a_before_once: assert property (p_before_once)
      else $error("before-stable re-armed at once after an edge");

   // bypass: the inverted input reaches the output one cycle later;
   // the edge that releases reset still resets the output, so skip it
   property p_bypass;
      @(posedge pclk) disable iff (!presetn)
      presetn && mode == DBF_BYPASS
         |=> cnt_out == ($past(cnt_in) ^ $past(inv));
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass output does not follow the input");

   // bypass with inversion: output opposes the raw input
   property p_bypass_inv;
      @(posedge pclk) disable iff (!presetn)
      mode == DBF_BYPASS && inv ##1 $stable(cnt_in) && $stable(inv)
         |-> cnt_out != cnt_in;
   endproperty
   a_bypass_inv: assert property (p_bypass_inv)
      else $error("bypass lost the edge selection");

endmodule

// *** dbf_pkg.sv ***
// shared constants and types for the counter input debounce filter
// assumes a 10 MHz pclk and an apb master on the register side
package dbf_pkg;

   // clock period in ns
   localparam int unsigned DBF_CLK_NS = 100;

   // number of selectable debounce times
   localparam int unsigned DBF_NSEL = 16;

   // debounce times in ns, shortest to longest
   localparam int unsigned DBF_DEB_NS [DBF_NSEL] = '{
      500, 1000, 2000, 5000, 10000, 20000, 50000, 100000,
      200000, 500000, 1000000, 2000000, 5000000, 10000000,
      20000000, 25500000};

   // width of a cycle count (255000 fits)
   localparam int unsigned DBF_CW = 18;

   // table of debounce counts in cycles
   typedef logic [DBF_CW-1:0] dbf_cyc_arr_t [DBF_NSEL];

   // each time rounds up to whole cycles, never below one
   function automatic dbf_cyc_arr_t dbf_cycles();
      dbf_cyc_arr_t c;
      for (int i = 0; i < DBF_NSEL; i++)
      begin
         c[i] = DBF_CW'((DBF_DEB_NS[i] + DBF_CLK_NS - 1) / DBF_CLK_NS);
         if (c[i] == '0)
         begin
            c[i] = DBF_CW'(1);
         end
      end
      return c;
   endfunction

   // debounce counts derived from the times and the clock
   localparam dbf_cyc_arr_t DBF_DEB_CYC = dbf_cycles();

   // register byte offsets
   localparam logic [7:0] DBF_OFS_CTRL = 8'h00;
   localparam logic [7:0] DBF_OFS_STAT = 8'h04;
   localparam logic [7:0] DBF_OFS_EDGE = 8'h08;

   // control field positions
   localparam int unsigned DBF_CTRL_MODE = 0;
   localparam int unsigned DBF_CTRL_INV = 2;
   localparam int unsigned DBF_CTRL_TSEL = 4;

   // reset values of the control fields
   localparam logic [1:0] DBF_RST_MODE = 2'h2;
   localparam logic DBF_RST_INV = 1'h0;
   localparam logic [3:0] DBF_RST_TSEL = 4'h0;

   // filter modes; the fourth code acts as bypass
   typedef enum logic [1:0] {
      DBF_AFTER,
      DBF_BEFORE,
      DBF_BYPASS
   } dbf_mode_t;

   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } dbf_apb_req_t;

   // apb answer to the master
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } dbf_apb_rsp_t;

endpackage

// *** dbf_stable_timer.sv ***
// stability timer: counts cycles since the input level last changed
// assumes the input is synchronous to pclk
module dbf_stable_timer
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic din, // level to watch
   input wire logic [dbf_pkg::DBF_CW-1:0] limit, // debounce count
   output logic lvl, // last sampled level
   output logic edge_now, // din differs from last sample
   output logic stable // lvl held for limit cycles
);
   import dbf_pkg::*;

   logic [DBF_CW-1:0] cnt; // cycles since last change
   logic [DBF_CW-1:0] next_cnt; // next value of cnt

   assign edge_now = din != lvl;
   assign stable = cnt >= limit;

   // restart on a change, else count up and hold at limit
   always_comb
   begin
      if (edge_now)
      begin
         next_cnt = '0;
      end
      else if (cnt < limit)
      begin
         next_cnt = cnt + DBF_CW'(1);
      end
      else
      begin
         next_cnt = cnt;
      end
   end

   // sample register and counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lvl <= 1'b0;
         cnt <= '0;
      end
      else
      begin
         lvl <= din;
         cnt <= next_cnt;
      end
   end

   // a change always restarts the count
   property p_restart;
      @(posedge pclk) disable iff (!presetn)
      edge_now |=> cnt == '0;
   endproperty
   a_restart: assert property (p_restart)
      else $error("stability count did not restart on a change");

   // an unchanged input below the limit counts up by one; the sampled
   // presetn keeps the edge that releases reset, still a reset edge, out
   property p_count_up;
      @(posedge pclk) disable iff (!presetn)
      presetn && !edge_now && cnt < limit
         |=> cnt == $past(cnt) + DBF_CW'(1);
   endproperty
   a_count_up: assert property (p_count_up)
      else $error("stability count failed to advance");

endmodule

// *** dbf_switch.sv ***
// partner model: a bouncing contact that feeds the filter input
// assumes the bench loads a level pattern, one level per pclk edge
module dbf_switch
(
   input wire logic pclk, // system clock
   input wire logic load, // take a new pattern
   input wire logic [31:0] pat, // levels, lsb first, msb then held
   output logic level // contact level to the filter
);
   logic [31:0] sh = '0; // levels still to come
   // shift one level per clock; the msb stays like a settled contact
   always_ff @(posedge pclk)
   begin
      if (load)
         sh <= pat;
      else
         sh <= {sh[31], sh[31:1]};
   end
   assign level = sh[0]; // present contact level
endmodule

// *** dbf_filter_tb.sv ***
// bench for the debounce filter: apb tasks plus a bouncing source
// assumes zero or more apb wait states and short debounce counts
module dbf_filter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import dbf_pkg::*;
   // short counts: selection i waits i+2 cycles
   function automatic dbf_cyc_arr_t mk_cyc();
      dbf_cyc_arr_t c;
      for (int i = 0; i < DBF_NSEL; i++)
         c[i] = DBF_CW'(i + 2);
      return c;
   endfunction
   localparam dbf_cyc_arr_t CYC = mk_cyc(); // counts handed to the design
   localparam int ND = int'(CYC[3]); // count of selection 3
   logic pclk = 1'b0; // system clock
   logic presetn = 1'b0; // reset, active low
   dbf_apb_req_t req = '0; // apb request
   dbf_apb_rsp_t rsp; // apb answer
   logic cnt_in; // contact level
   logic cnt_out; // filtered level
   logic ld = 1'b0; // pattern load strobe
   logic [31:0] pat = '0; // pattern for the contact
   logic [31:0] q; // last read data
   logic er; // last error flag
   logic [31:0] e0; // edge count before a test
   int bad_count = 0; // mismatches
   int num_checks = 0; // comparisons
   always #50 pclk = ~pclk;
   dbf_filter #(.DEB_CYCLES(CYC)) dut_u (.pclk(pclk), .presetn(presetn),
      .apb_req(req), .apb_rsp(rsp), .cnt_in(cnt_in), .cnt_out(cnt_out));
   dbf_switch sw_u (.pclk(pclk), .load(ld), .pat(pat), .level(cnt_in));
   // count and report one comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string m);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer; held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do
         @(posedge pclk);
      while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   // start a bounce pattern on the contact
   task automatic bounce(input logic [31:0] p);
      @(posedge pclk);
      ld <= 1'b1;
      pat <= p;
      @(posedge pclk);
      ld <= 1'b0;
   endtask
   task automatic test_done();
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // watchdog against a hung transfer
   initial
   begin
      cyc(20000);
      bad_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      test_done();
   end
   // main sequence
   initial
   begin
      cyc(10);
      presetn <= 1'b1;
      apb(1'b0, DBF_OFS_CTRL, '0);
      chk(q, 32'h2, "ctrl reset");
      apb(1'b0, DBF_OFS_EDGE, '0);
      chk(q, 32'h0, "edge count reset");
      apb(1'b0, 8'h0C, '0);
      chk({q[30:0], er}, 32'h1, "unmapped read");
      apb(1'b1, DBF_OFS_CTRL, 32'hFFFFFFFF);
      apb(1'b0, DBF_OFS_CTRL, '0);
      chk(q, 32'hF7, "ctrl fields");
      $display("registers done");
      // bypass, inverted, longest time ignored
      apb(1'b1, DBF_OFS_CTRL, 32'hF6);
      cyc(3);
      chk(32'(cnt_out), 32'h1, "inverted idle");
      apb(1'b0, DBF_OFS_EDGE, '0);
      e0 = q;
      bounce(32'h555);
      cyc(40);
      apb(1'b0, DBF_OFS_EDGE, '0);
      chk(q, e0 + 32'hC, "bypass glitches");
      $display("bypass done");
      // after stable, time chosen between glitch and pulse width
      apb(1'b1, DBF_OFS_CTRL, 32'h30);
      cyc(20);
      apb(1'b0, DBF_OFS_EDGE, '0);
      e0 = q;
      bounce(32'hF);
      cyc(20);
      apb(1'b0, DBF_OFS_EDGE, '0);
      chk(q, e0, "short excursion");
      bounce(32'hFFFFFFFF);
      cyc(ND + 2);
      chk(32'(cnt_out), 32'h0, "early after stable");
      cyc(1);
      chk(32'(cnt_out), 32'h1, "late after stable");
      apb(1'b0, DBF_OFS_STAT, '0);
      chk(q, 32'h7, "status settled");
      $display("after stable done");
      // before stable
      apb(1'b1, DBF_OFS_CTRL, 32'h31);
      cyc(10);
      bounce(32'h0);
      cyc(2);
      chk(32'(cnt_out), 32'h0, "edge at once");
      cyc(10);
      apb(1'b0, DBF_OFS_EDGE, '0);
      e0 = q;
      bounce(32'hFFFFF333);
      cyc(30);
      chk(32'(cnt_out), 32'h1, "burst held");
      apb(1'b0, DBF_OFS_EDGE, '0);
      chk(q, e0 + 32'h1, "burst counted once");
      bounce(32'hFFFFFFF2);
      cyc(30);
      chk(32'(cnt_out), 32'h0, "unstable edge refused");
      apb(1'b0, DBF_OFS_EDGE, '0);
      chk(q, e0 + 32'h2, "one more edge");
      $display("before stable done");
      test_done();
   end
endmodule
